// file: hw/motor_load_pkg.sv
package motor_load_pkg;

    // Register indices on the plain register port
    localparam logic [2:0] ADDR_LOAD_CONFIG     = 3'h0;
    localparam logic [2:0] ADDR_CONSIST_LIMIT   = 3'h1;
    localparam logic [2:0] ADDR_NORMAL_LIMIT    = 3'h2;
    localparam logic [2:0] ADDR_SETPOINT_MULT   = 3'h3;
    localparam logic [2:0] ADDR_PROP_GAIN       = 3'h4;
    localparam logic [2:0] ADDR_INTEG_GAIN      = 3'h5;
    localparam logic [2:0] ADDR_DERIV_GAIN      = 3'h6;
    localparam logic [2:0] ADDR_STATUS          = 3'h7;

    // Reset values
    localparam logic [7:0] RST_LOAD_CONFIG      = 8'h01;
    localparam logic [7:0] RST_CONSIST_LIMIT    = 8'h96;
    localparam logic [7:0] RST_NORMAL_LIMIT     = 8'hc8;
    localparam logic [7:0] RST_SETPOINT_MULT    = 8'h50;
    localparam logic [7:0] RST_PROP_GAIN        = 8'h03;
    localparam logic [7:0] RST_INTEG_GAIN       = 8'h03;
    localparam logic [7:0] RST_DERIV_GAIN       = 8'h80;

    // Field positions
    localparam int LOAD_LOOP_ENABLE_BIT = 0;
    localparam int FLAG_SHORT_BIT       = 0;

    // Gain range
    localparam logic [7:0] GAIN_MIN     = 8'h01;
    localparam logic [7:0] GAIN_MAX     = 8'h09;

    // Carrier timing
    localparam int  CLK_HZ              = 100_000_000;
    localparam int  PWM_HZ              = 20_000;
    localparam int  PWM_PERIOD_CYC      = CLK_HZ / PWM_HZ;

    // Fixed point: set point = speed * multiplier >> MULT_SHIFT
    localparam int  MULT_SHIFT          = 6;
    localparam int  DERIV_SHIFT         = 7;
    localparam int  INTEG_SHIFT         = 4;

    typedef struct packed {
        logic       fwd_hi;
        logic       fwd_lo;
        logic       rev_hi;
        logic       rev_lo;
    } bridge_drive_s;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_TRIP = 2'b01
    } drive_state_e;

endpackage : motor_load_pkg

// file: hw/motor_load_control_pwm.sv
`timescale 1ns/1ps
module motor_load_control_pwm
    import motor_load_pkg::*;
#(
    parameter int PERIOD_CYC = PWM_PERIOD_CYC
)(
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic [2:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [7:0]    reg_rdata,
    input  wire logic [7:0]    speed_cmd,
    input  wire logic          direction_fwd,
    input  wire logic          consist_active,
    input  wire logic [7:0]    back_emf,
    input  wire logic          short_detect,
    output bridge_drive_s      bridge,
    output logic      [7:0]    feedback_flags
);

    localparam int CW = $clog2(PERIOD_CYC + 1);

    // ************************************************
    // Input synchronisers
    // ************************************************
    logic [1:0] short_sync_q;
    logic [1:0] cons_sync_q;
    logic [1:0] dir_sync_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            short_sync_q <= 2'h0;
            cons_sync_q  <= 2'h0;
            dir_sync_q   <= 2'h0;
        end
        else
        begin
            short_sync_q <= {short_sync_q[0], short_detect};
            cons_sync_q  <= {cons_sync_q[0], consist_active};
            dir_sync_q   <= {dir_sync_q[0], direction_fwd};
        end
    end

    wire logic short_s = short_sync_q[1];
    wire logic cons_s  = cons_sync_q[1];
    wire logic dir_s   = dir_sync_q[1];

    // ************************************************
    // Registers
    // ************************************************
    logic [7:0] load_config_bits_q;
    logic [7:0] consist_output_limit_q;
    logic [7:0] normal_output_limit_q;
    logic [7:0] setpoint_multiplier_q;
    logic [7:0] proportional_gain_q;
    logic [7:0] integral_gain_q;
    logic [7:0] derivative_gain_q;
    drive_state_e state_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_config_bits_q     <= RST_LOAD_CONFIG;
            consist_output_limit_q <= RST_CONSIST_LIMIT;
            normal_output_limit_q  <= RST_NORMAL_LIMIT;
            setpoint_multiplier_q  <= RST_SETPOINT_MULT;
            proportional_gain_q    <= RST_PROP_GAIN;
            integral_gain_q        <= RST_INTEG_GAIN;
            derivative_gain_q      <= RST_DERIV_GAIN;
        end
        else if (reg_wr)
        begin
            // Written values reach the regulator on the next cycle
            case (reg_addr)
                ADDR_LOAD_CONFIG:   load_config_bits_q     <= reg_wdata;
                ADDR_CONSIST_LIMIT: consist_output_limit_q <= reg_wdata;
                ADDR_NORMAL_LIMIT:  normal_output_limit_q  <= reg_wdata;
                ADDR_SETPOINT_MULT: setpoint_multiplier_q  <= reg_wdata;
                ADDR_PROP_GAIN:     proportional_gain_q    <= reg_wdata;
                ADDR_INTEG_GAIN:    integral_gain_q        <= reg_wdata;
                ADDR_DERIV_GAIN:    derivative_gain_q      <= reg_wdata;
                default:            ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                ADDR_LOAD_CONFIG:   reg_rdata <= load_config_bits_q;
                ADDR_CONSIST_LIMIT: reg_rdata <= consist_output_limit_q;
                ADDR_NORMAL_LIMIT:  reg_rdata <= normal_output_limit_q;
                ADDR_SETPOINT_MULT: reg_rdata <= setpoint_multiplier_q;
                ADDR_PROP_GAIN:     reg_rdata <= proportional_gain_q;
                ADDR_INTEG_GAIN:    reg_rdata <= integral_gain_q;
                ADDR_DERIV_GAIN:    reg_rdata <= derivative_gain_q;
                ADDR_STATUS:        reg_rdata <= feedback_flags;
                default:            reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // ************************************************
    // Short-circuit latch
    // ************************************************
    // Only rst_n (power-on) leaves the trip state; the register port cannot
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ST_RUN;
        else
        begin
            case (state_q)
                ST_RUN:  if (short_s) state_q <= ST_TRIP;
                ST_TRIP: state_q <= ST_TRIP;
                default: state_q <= ST_TRIP;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            feedback_flags <= 8'h00;
        else
            feedback_flags <= 8'(state_q == ST_TRIP) << FLAG_SHORT_BIT;
    end

    // ************************************************
    // Regulator
    // ************************************************
    function automatic logic [3:0] eff_gain(input logic [7:0] g);
        if (g < GAIN_MIN || g > GAIN_MAX)
            return 4'(GAIN_MAX);
        return g[3:0];
    endfunction : eff_gain

    // Integrator saturates instead of wrapping, so a long stall cannot flip its sign
    function automatic logic signed [15:0] sat_add(input logic signed [15:0] a,
                                                   input logic signed [15:0] b);
        logic signed [16:0] s;
        s = 17'(a) + 17'(b);
        if (s > 17'sd32767)
            return 16'sh7fff;
        if (s < -17'sd32768)
            return 16'sh8000;
        return s[15:0];
    endfunction : sat_add

    logic [CW-1:0]      pwm_cnt_q;
    logic               cycle_end;
    logic signed [15:0] integ_q;
    logic signed [15:0] prev_err_q;
    logic [7:0]         duty_q;

    assign cycle_end = (pwm_cnt_q == CW'(PERIOD_CYC - 1));

    // Set point: speed times multiplier shifted right by MULT_SHIFT, saturated to 8 bits
    logic [15:0] sp_prod;
    logic [7:0]  setpoint;
    assign sp_prod  = 16'(speed_cmd) * 16'(setpoint_multiplier_q) >> MULT_SHIFT;
    assign setpoint = (sp_prod > 16'h00ff) ? 8'hff : sp_prod[7:0];

    logic [7:0]         limit;
    logic signed [15:0] err;
    logic signed [15:0] derr;
    logic signed [23:0] pid;
    logic signed [23:0] p_term;
    logic signed [23:0] i_term;
    logic signed [23:0] d_term;
    logic [7:0]         raw;

    // Limit is used directly as duty ceiling, hence monotonic
    assign limit = cons_s ? consist_output_limit_q : normal_output_limit_q;
    assign err   = 16'(setpoint) - 16'(back_emf);
    assign derr  = err - prev_err_q;

    always_comb
    begin
        p_term = 24'(err * $signed({12'h000, eff_gain(proportional_gain_q)}));
        i_term = 24'(integ_q >>> INTEG_SHIFT);
        // Widened before the product: a full error swing times 255 overflows 16 bits
        d_term = ($signed(24'(derr)) * $signed({16'h0000, derivative_gain_q})) >>> DERIV_SHIFT;
        pid    = p_term + i_term + d_term;
        if (load_config_bits_q[LOAD_LOOP_ENABLE_BIT])
            raw = (pid < 0) ? 8'h00 : (pid > 24'sd255) ? 8'hff : pid[7:0];
        else
            raw = setpoint;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            integ_q    <= 16'sh0000;
            prev_err_q <= 16'sh0000;
            duty_q     <= 8'h00;
        end
        else if (cycle_end)
        begin
            prev_err_q <= err;
            if (load_config_bits_q[LOAD_LOOP_ENABLE_BIT])
                integ_q <= sat_add(integ_q, 16'(err * $signed({12'h000, eff_gain(integral_gain_q)}) >>> INTEG_SHIFT));
            else
                integ_q <= 16'sh0000;
            // Clamp never touches the trip state
            duty_q <= (raw > limit) ? limit : raw;
        end
    end

    // ************************************************
    // PWM carrier and bridge
    // ************************************************
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pwm_cnt_q <= '0;
        else if (cycle_end)
            pwm_cnt_q <= '0;
        else
            pwm_cnt_q <= pwm_cnt_q + CW'(1);
    end

    // Compare duty/255 of the period
    logic [CW+7:0] on_thr;
    logic          pwm_on;
    assign on_thr = (CW+8)'(duty_q) * (CW+8)'(PERIOD_CYC) / (CW+8)'(255);
    assign pwm_on = ((CW+8)'(pwm_cnt_q) < on_thr);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            bridge <= '0;
        else if (state_q == ST_TRIP || short_s)
            bridge <= '0;
        else
        begin
            bridge.fwd_hi <= dir_s & pwm_on;
            bridge.rev_lo <= dir_s & pwm_on;
            bridge.rev_hi <= ~dir_s & pwm_on;
            bridge.fwd_lo <= ~dir_s & pwm_on;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    sequence seq_bypass_sample;
        cycle_end && !load_config_bits_q[LOAD_LOOP_ENABLE_BIT];
    endsequence

    AST_TRIP_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == ST_TRIP |=> bridge == '0)
        else $error("bridge on after trip");
    AST_TRIP_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == ST_TRIP |=> state_q == ST_TRIP)
        else $error("trip cleared");
    AST_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(state_q == ST_TRIP) |=> feedback_flags[FLAG_SHORT_BIT])
        else $error("flag not set");
    AST_PERIOD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cycle_end |=> pwm_cnt_q == '0)
        else $error("carrier period wrong");
    AST_LIMIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(cycle_end) |-> duty_q <= $past(limit))
        else $error("duty above limit");
    AST_BYPASS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seq_bypass_sample and setpoint <= limit |=> duty_q == $past(setpoint))
        else $error("bypass duty wrong");
    AST_GAIN9: assert property (@(posedge ref_clk) disable iff (!rst_n)
        proportional_gain_q > GAIN_MAX |-> eff_gain(proportional_gain_q) == 4'h9)
        else $error("gain clamp");
    AST_NO_SHOOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(bridge.fwd_hi && bridge.fwd_lo) && !(bridge.rev_hi && bridge.rev_lo))
        else $error("shoot through");

    // ************************************************
    // Checks: short latch and feedback flag
    // ************************************************
    sequence seq_short_seen;
        state_q == ST_RUN && short_s;
    endsequence

    sequence seq_trip_entry;
        state_q == ST_RUN ##1 state_q == ST_TRIP;
    endsequence

    AST_SHORT_TRIP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seq_short_seen |=> state_q == ST_TRIP)
        else $error("short not latched");
    AST_SHORT_BRIDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        short_s |=> bridge == '0)
        else $error("bridge on during short");
    AST_FLAG_ENTRY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seq_trip_entry |=> feedback_flags[FLAG_SHORT_BIT])
        else $error("flag missed trip entry");
    // The limit clamp must never be able to fake an alarm
    AST_FLAG_ONLY_TRIP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        feedback_flags[FLAG_SHORT_BIT] |-> $past(state_q == ST_TRIP))
        else $error("flag without trip");
    AST_FLAG_SPARE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (feedback_flags & ~(8'h01 << FLAG_SHORT_BIT)) == 8'h00)
        else $error("spare flag bit set");

    // ************************************************
    // Checks: register port
    // ************************************************
    AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_RDATA_STATUS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata == $past(feedback_flags))
        else $error("status read wrong");
    AST_WRITE_NOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr && reg_addr == ADDR_PROP_GAIN |=> proportional_gain_q == $past(reg_wdata))
        else $error("gain write not applied");

    // ************************************************
    // Checks: regulator and bridge
    // ************************************************
    AST_LOOP_OFF_INTEG: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seq_bypass_sample |=> integ_q == 16'sh0000)
        else $error("integrator runs with loop off");
    AST_DUTY_STEADY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !cycle_end |=> $stable(duty_q))
        else $error("duty changed mid period");
    AST_DERIV_STEADY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        derr == 16'sh0000 |-> d_term == 24'sh000000)
        else $error("derivative acts on steady error");
    AST_LIMIT_CONSIST: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cycle_end && cons_s |=> duty_q <= $past(consist_output_limit_q))
        else $error("consist limit exceeded");
    AST_LIMIT_NORMAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cycle_end && !cons_s |=> duty_q <= $past(normal_output_limit_q))
        else $error("normal limit exceeded");
    AST_DIR_PAIR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bridge.fwd_hi == bridge.rev_lo && bridge.rev_hi == bridge.fwd_lo)
        else $error("bridge diagonal split");

endmodule : motor_load_control_pwm

// file: sim/motor_model.sv
`timescale 1ns/1ps
module motor_model
    import motor_load_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire bridge_drive_s bridge,
    input  wire logic          inject_short,
    output logic      [7:0]    back_emf,
    output logic               short_detect
);
    // ************************************************
    // Behavioural motor: speed rises while driven, coasts down otherwise
    // ************************************************
    logic [11:0] speed_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            speed_q <= 12'h000;
        else if ((bridge.fwd_hi | bridge.rev_hi) && speed_q != 12'hfff)
            speed_q <= speed_q + 12'h001;
        else if (speed_q != 12'h000)
            speed_q <= speed_q - 12'h001;
    end

    assign back_emf     = speed_q[11:4];
    // Shorted winding seen by the sense amplifier as a level
    assign short_detect = inject_short;
endmodule : motor_model

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import motor_load_pkg::*;
    localparam int P = 50;
    logic ref_clk, rst_n, reg_wr, reg_rd, dir_fwd, consist, inj;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, speed_cmd, back_emf, feedback_flags, rd_v;
    logic short_detect;
    bridge_drive_s bridge;
    int errors, n_compared, seed, on, per, i, e;
    wire hi = bridge.fwd_hi | bridge.rev_hi;
    motor_load_control_pwm #(.PERIOD_CYC(P)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .speed_cmd(speed_cmd),
        .direction_fwd(dir_fwd), .consist_active(consist), .back_emf(back_emf), .short_detect(short_detect),
        .bridge(bridge), .feedback_flags(feedback_flags));
    motor_model u_motor (.ref_clk(ref_clk), .rst_n(rst_n), .bridge(bridge), .inject_short(inj),
        .back_emf(back_emf), .short_detect(short_detect));
    // ************************************************
    // Helpers
    // ************************************************
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) begin @(posedge ref_clk); #1; end
    endtask : tick
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Sync to a rising edge of the high side, then time one carrier period
    task automatic measure();
        on = 0; per = 0;
        for (i = 0; i < 300 && hi !== 1'b0; i++) tick(1);
        for (i = 0; i < 300 && hi !== 1'b1; i++) tick(1);
        while (hi === 1'b1 && per < 300) begin on++; per++; tick(1); end
        while (hi === 1'b0 && per < 300) begin per++; tick(1); end
        if (per >= 300)
        begin
            errors++;
            print_verdict();
        end
    endtask : measure
    function automatic int exp_on(input int spd, input int mult, input int lim);
        int sp;
        sp = (spd * mult) >> MULT_SHIFT;
        if (sp > 255) sp = 255;
        if (sp > lim) sp = lim;
        return sp * P / 255;
    endfunction : exp_on
    // ************************************************
    // Stimulus
    // ************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        logic [7:0] rst_tab [8];
        logic [7:0] v;
        int lim, mult, spd;
        rst_tab = '{RST_LOAD_CONFIG, RST_CONSIST_LIMIT, RST_NORMAL_LIMIT, RST_SETPOINT_MULT,
                    RST_PROP_GAIN, RST_INTEG_GAIN, RST_DERIV_GAIN, 8'h00};
        errors = 0; n_compared = 0; seed = 32'h816f;
        rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0; reg_wdata = 8'h00;
        speed_cmd = 8'h00; dir_fwd = 1'b1; consist = 1'b0; inj = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++)
        begin
            rd(a[2:0], rd_v);
            check(rd_v, rst_tab[a]);
        end
        for (int a = 0; a < 8; a++)
        begin
            v = $random(seed);
            wr(a[2:0], v);
            rd(a[2:0], rd_v);
            check(rd_v, (a == 7) ? 8'h00 : v);
        end
        wr(ADDR_LOAD_CONFIG, 8'h00);
        wr(ADDR_CONSIST_LIMIT, 8'h50);
        wr(ADDR_NORMAL_LIMIT, 8'hc8);
        for (int k = 0; k < 6; k++)
        begin
            spd = ($random(seed) & 8'h7f) + 8'h40;
            mult = ($random(seed) & 8'h3f) + 8'h30;
            @(posedge ref_clk);
            speed_cmd <= spd[7:0]; consist <= k[0]; dir_fwd <= k[1];
            wr(ADDR_SETPOINT_MULT, mult[7:0]);
            lim = k[0] ? 8'h50 : 8'hc8;
            tick(3 * P);
            measure();
            check(per, P);
            e = exp_on(spd, mult, lim) - on;
            check(e >= -1 && e <= 1, 1'b1);
            check(feedback_flags, 8'h00);
            for (i = 0; i < 300 && hi !== 1'b1; i++) tick(1);
            check(bridge, k[1] ? 4'b1001 : 4'b0110);
        end
        wr(ADDR_LOAD_CONFIG, 8'h01);
        wr(ADDR_PROP_GAIN, 8'h0c);
        @(posedge ref_clk);
        speed_cmd <= 8'hff; consist <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            tick(2 * P);
            measure();
            check(per, P);
            check(on <= 8'h50 * P / 255, 1'b1);
        end
        @(posedge ref_clk);
        inj <= 1'b1;
        for (i = 0; i < 8 && (bridge !== 4'b0000 || feedback_flags[FLAG_SHORT_BIT] !== 1'b1); i++) tick(1);
        check({bridge, feedback_flags}, {4'b0000, 8'h01});
        @(posedge ref_clk);
        inj <= 1'b0;
        wr(ADDR_LOAD_CONFIG, 8'h00);
        wr(ADDR_STATUS, 8'h00);
        for (i = 0; i < 3 * P; i++)
        begin
            tick(1);
            check(bridge, 4'b0000);
        end
        rd(ADDR_STATUS, rd_v);
        check(rd_v, 8'h01);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(2 * P);
        check(feedback_flags, 8'h00);
        print_verdict();
    end
endmodule : tb
